// File: dcfg_config_id_otp.sv
// Contract
// - option bit 13 routes second host SPI through remap fabric when 1.
// - option bit 10 selects SMBus 3.0 input thresholds when 1.
// - level selection only matters when the I2C SMBus mode enable is set; here smbusHighLevelEnable follows bit 10 regardless.
// - option bit 3 puts first I2C pins on default pins when 1.
// - unimplemented configuration bits read back as 1.
// - context code n maps set to level n+1; code 111 unassigned.
// - context fields for sets 4..1 at bits 14-12, 10-8, 6-4, 2-0.
// - two identification registers: part identifier and silicon revision.
// - identification registers read-only; revision in bits 3-0, upper bits zero.
// - identifier bits 15-8 hold family code, bits 23-16 read zero.
// - identifier bits 7-0 hold individual part code.
// - user memory holds 64 write-once words of 48 bits.
// - each write-once word programmed once; device never alters it afterwards. Here srst resets every word to all ones and clears otpWritten.
// - no erase command clears or modifies the write-once memory.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
module dcfg_config_id_otp
  import dcfg_pkg::*;
#(
  // Arbitrary identity values
  parameter logic [7:0] FAMILY_CODE = 8'h5A,
  parameter logic [7:0] PART_CODE = 8'h21,
  parameter logic [3:0] REVISION = 4'h1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [23:0] nvOptWord,
  input wire logic [23:0] nvCtxWord,
  input wire logic smbusModeEnable,
  output logic hostSpiUseRemap,
  output logic smbusHighLevelEnable,
  output logic smbusInputHighLevel,
  output logic i2cDefaultPins,
  output logic [11:0] ctxLevel,
  output logic [3:0] ctxAssigned,
  output logic configLoaded
);

  // ==========================================================
  // Configuration load
  dcfg_load_t loadState, next_loadState;
  logic [23:0] optWord, next_optWord;
  logic [23:0] ctxWord, next_ctxWord;

  always_comb begin
    next_loadState = loadState;
    next_optWord = optWord;
    next_ctxWord = ctxWord;
    unique case (loadState)
      LD_FETCH: begin
        next_optWord = nvOptWord | OPT_UNIMPL_MASK;
        next_ctxWord = nvCtxWord | CTX_UNIMPL_MASK;
        next_loadState = LD_RUN;
      end
      LD_RUN: begin
        next_loadState = LD_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      loadState <= LD_FETCH;
      optWord <= CFG_ERASED;
      ctxWord <= CFG_ERASED;
    end else begin
      loadState <= next_loadState;
      optWord <= next_optWord;
      ctxWord <= next_ctxWord;
    end
  end

  assign configLoaded = (loadState == LD_RUN);

  // ==========================================================
  // Option outputs
  // remap fabric route
  assign hostSpiUseRemap = optWord[SPI_PAD_BIT];
  assign smbusHighLevelEnable = optWord[SMB_LEVEL_BIT];
  assign smbusInputHighLevel = optWord[SMB_LEVEL_BIT] && smbusModeEnable;
  assign i2cDefaultPins = optWord[I2C_MAP_BIT];

  // ==========================================================
  // Context sets
  genvar g;
  for (g = 0; g < CTX_SETS; g++) begin : g_ctx
    dcfg_ctx_if ctxLink();
    assign ctxLink.code = ctxWord[g * CTX_FIELD_STEP +: CODE_BITS];
    dcfg_ctx_decode u_dec (
      .clk_sys(clk_sys),
      .srst(srst),
      .ctx(ctxLink)
    );
    assign ctxLevel[g * CODE_BITS +: CODE_BITS] = ctxLink.level;
    assign ctxAssigned[g] = ctxLink.assigned;
  end

  // ==========================================================
  // Bus address and data phase
  logic addrTake;
  logic wrPend, next_wrPend;
  logic [11:0] wrAddr, next_wrAddr;
  logic [31:0] next_hrdata;
  logic [11:0] rdOff;
  logic [OTP_IDX_BITS-1:0] rdIdx;

  assign addrTake = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  // ==========================================================
  // Write-once memory
  logic [OTP_BITS-1:0] otpMem [OTP_WORDS];
  logic [OTP_BITS-1:0] next_otpMem [OTP_WORDS];
  logic [OTP_WORDS-1:0] otpWritten, next_otpWritten;
  logic [15:0] stageHi, next_stageHi;
  logic [1:0] status, next_status;
  logic [11:0] wrOff;
  logic [OTP_IDX_BITS-1:0] wrIdx;
  logic wrIsOtp;
  logic rejectEvt;
  logic eraseEvt;
  logic programEvt;

  // 64 words at eight bytes each
  assign wrOff = wrAddr - ADDR_OTP_BASE;
  assign wrIdx = wrOff[8:3];
  assign wrIsOtp = wrPend && (wrOff < OTP_SPAN) && !wrAddr[2];

  always_comb begin
    next_otpMem = otpMem;
    next_otpWritten = otpWritten;
    next_stageHi = stageHi;
    next_status = status;
    rejectEvt = 1'b0;
    eraseEvt = 1'b0;
    programEvt = 1'b0;
    if (wrPend && wrAddr == ADDR_STAGE) begin
      next_stageHi = hwdata[15:0];
    end
    if (wrPend && wrAddr == ADDR_STATUS) begin
      next_status = status & ~hwdata[1:0];
    end
    // erase touches only the staging word and the erase status bit
    if (wrPend && wrAddr == ADDR_ERASE) begin
      next_stageHi = STAGE_RESET;
      eraseEvt = 1'b1;
    end
    if (wrIsOtp) begin
      if (otpWritten[wrIdx]) begin
        rejectEvt = 1'b1;
      end else begin
        next_otpMem[wrIdx] = {stageHi, hwdata};
        next_otpWritten[wrIdx] = 1'b1;
        programEvt = 1'b1;
      end
    end
    // Set wins over clear
    if (rejectEvt) begin
      next_status[ST_REJECT_BIT] = 1'b1;
    end
    if (eraseEvt) begin
      next_status[ST_ERASE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      otpWritten <= '0;
      stageHi <= STAGE_RESET;
      status <= STATUS_RESET;
      for (int i = 0; i < OTP_WORDS; i++) begin
        otpMem[i] <= OTP_ERASED;
      end
    end else begin
      otpWritten <= next_otpWritten;
      stageHi <= next_stageHi;
      status <= next_status;
      otpMem <= next_otpMem;
    end
  end

  // ==========================================================
  // Read mux, forwarded from pending write
  assign rdOff = haddr[11:0] - ADDR_OTP_BASE;
  assign rdIdx = rdOff[8:3];

  always_comb begin
    next_wrPend = addrTake && hwrite && (hsize == HSIZE_WORD);
    next_wrAddr = addrTake ? haddr[11:0] : wrAddr;
    next_hrdata = 32'h0000_0000;
    if (addrTake && !hwrite) begin
      if (haddr[11:0] == ADDR_OPT) begin
        next_hrdata = {8'h00, optWord};
      end else if (haddr[11:0] == ADDR_CTX) begin
        next_hrdata = {8'h00, ctxWord};
      end else if (haddr[11:0] == ADDR_REV) begin
        next_hrdata = {28'h000_0000, REVISION};
      end else if (haddr[11:0] == ADDR_ID) begin
        next_hrdata = {16'h0000, FAMILY_CODE, PART_CODE};
      end else if (haddr[11:0] == ADDR_STAGE) begin
        next_hrdata = {16'h0000, next_stageHi};
      end else if (haddr[11:0] == ADDR_STATUS) begin
        next_hrdata = {30'h0000_0000, next_status};
      end else if (rdOff < OTP_SPAN) begin
        next_hrdata = haddr[2] ? {16'h0000, next_otpMem[rdIdx][47:32]}
                               : next_otpMem[rdIdx][31:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPend <= 1'b0;
      wrAddr <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else begin
      wrPend <= next_wrPend;
      wrAddr <= next_wrAddr;
      hrdata <= next_hrdata;
    end
  end

  // ==========================================================
  // Checks
  // Flat copy of the memory for whole-array comparisons
  logic [OTP_WORDS*OTP_BITS-1:0] otpFlat;
  genvar w;
  for (w = 0; w < OTP_WORDS; w++) begin : g_flat
    assign otpFlat[w * OTP_BITS +: OTP_BITS] = otpMem[w];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  spi_route_a: assert property (configLoaded |-> hostSpiUseRemap == optWord[13])
    else $error("spi route differs from option bit");
  smb_level_a: assert property (configLoaded |-> smbusHighLevelEnable == optWord[10])
    else $error("smbus level differs from option bit");
  smb_gate_a: assert property (!smbusModeEnable |-> !smbusInputHighLevel)
    else $error("high levels without smbus mode");
  i2c_map_a: assert property (configLoaded |-> i2cDefaultPins == optWord[3])
    else $error("i2c pin map differs from option bit");
  unimpl_read_a: assert property (
    (addrTake && !hwrite && haddr[11:0] == ADDR_CTX && configLoaded)
      |=> ((hrdata[23:0] & CTX_UNIMPL_MASK) == CTX_UNIMPL_MASK) && hrdata[31:24] == 8'h00)
    else $error("unimplemented context bits not one");
  rev_read_a: assert property (
    (addrTake && !hwrite && haddr[11:0] == ADDR_REV)
      |=> hrdata == {28'h000_0000, REVISION})
    else $error("revision read wrong");
  id_read_a: assert property (
    (addrTake && !hwrite && haddr[11:0] == ADDR_ID)
      |=> hrdata[31:16] == 16'h0000 && hrdata[15:8] == FAMILY_CODE
          && hrdata[7:0] == PART_CODE)
    else $error("identifier read wrong");
  otp_once_a: assert property (
    (wrIsOtp && otpWritten[wrIdx]) |=> otpFlat == $past(otpFlat) && status[ST_REJECT_BIT])
    else $error("written word altered or refusal lost");
  otp_prog_a: assert property (
    (wrIsOtp && !otpWritten[wrIdx]) |=> otpWritten[$past(wrIdx)]
      && otpMem[$past(wrIdx)] == {$past(stageHi), $past(hwdata)})
    else $error("first program not stored");
  erase_keep_a: assert property (
    eraseEvt |=> otpFlat == $past(otpFlat) && otpWritten == $past(otpWritten))
    else $error("erase changed write-once memory");
  erase_stage_a: assert property (
    eraseEvt |=> status[ST_ERASE_BIT] && stageHi == STAGE_RESET)
    else $error("erase did not reset staging word");
  cfg_hold_a: assert property (configLoaded |=> $stable(optWord) && $stable(ctxWord))
    else $error("configuration changed after load");
  ctx_fields_a: assert property (
    configLoaded |-> ctxAssigned == {ctxWord[14:12] != CTX_UNASSIGNED,
      ctxWord[10:8] != CTX_UNASSIGNED, ctxWord[6:4] != CTX_UNASSIGNED,
      ctxWord[2:0] != CTX_UNASSIGNED})
    else $error("context field positions wrong");
  otp_blank_a: assert property (
    (addrTake && !hwrite && rdOff < OTP_SPAN && !next_otpWritten[rdIdx])
      |=> hrdata == ($past(haddr[2]) ? 32'h0000_FFFF : 32'hFFFF_FFFF))
    else $error("blank write-once word not all ones");

  prog_c: cover property (programEvt ##1 rejectEvt);
  erase_c: cover property (eraseEvt);
  otp_read_c: cover property (addrTake && !hwrite && rdOff < OTP_SPAN);
  ctx_set_c: cover property (configLoaded && ctxAssigned == 4'hF);

endmodule

// File: dcfg_pkg.sv
// ==========================================================
// Shared constants for the configuration and OTP block
package dcfg_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned CFG_BITS = 24;
  localparam int unsigned OTP_WORDS = 64;
  localparam int unsigned OTP_BITS = 48;
  localparam int unsigned OTP_HI_BITS = 16;
  localparam int unsigned OTP_IDX_BITS = 6;
  localparam int unsigned CTX_SETS = 4;
  localparam int unsigned CODE_BITS = 3;
  localparam int unsigned CTX_FIELD_STEP = 4;
  localparam int unsigned REV_BITS = 4;
  localparam int unsigned ADDR_BITS = 12;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] ADDR_OPT = 12'h000;
  localparam logic [11:0] ADDR_CTX = 12'h004;
  localparam logic [11:0] ADDR_REV = 12'h008;
  localparam logic [11:0] ADDR_ID = 12'h00C;
  localparam logic [11:0] ADDR_STAGE = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_ERASE = 12'h018;
  localparam logic [11:0] ADDR_OTP_BASE = 12'h100;
  localparam logic [11:0] OTP_SPAN = 12'h200;

  // ==========================================================
  // Field positions
  localparam int unsigned SPI_PAD_BIT = 13;
  localparam int unsigned SMB_LEVEL_BIT = 10;
  localparam int unsigned I2C_MAP_BIT = 3;
  localparam int unsigned ST_REJECT_BIT = 0;
  localparam int unsigned ST_ERASE_BIT = 1;

  // ==========================================================
  // Masks and values after reset
  localparam logic [23:0] OPT_UNIMPL_MASK = 24'hFF_D873;
  localparam logic [23:0] CTX_UNIMPL_MASK = 24'hFF_8888;
  localparam logic [23:0] CFG_ERASED = 24'hFF_FFFF;
  localparam logic [47:0] OTP_ERASED = 48'hFFFF_FFFF_FFFF;
  localparam logic [15:0] STAGE_RESET = 16'hFFFF;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [2:0] CTX_UNASSIGNED = 3'h7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {
    LD_FETCH = 1'b0,
    LD_RUN = 1'b1
  } dcfg_load_t;

endpackage

// File: dcfg_ctx_if.sv
// ==========================================================
// One context field and its decoded level
interface dcfg_ctx_if;
  logic [2:0] code;
  logic [2:0] level;
  logic assigned;
  modport dec(input code, output level, output assigned);
  modport user(output code, input level, input assigned);
endinterface

// File: dcfg_ctx_decode.sv
// ==========================================================
// Context field to priority level
module dcfg_ctx_decode
  import dcfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  dcfg_ctx_if.dec ctx
);

  always_comb begin
    ctx.assigned = (ctx.code != CTX_UNASSIGNED);
    ctx.level = ctx.assigned ? 3'(ctx.code + 3'h1) : 3'h0;
  end

  // ==========================================================
  // Checks
  ctx_map_a: assert property (@(posedge clk_sys) disable iff (srst)
    (ctx.code != CTX_UNASSIGNED) |-> (ctx.assigned && ctx.level == 3'(ctx.code + 3'h1)))
    else $error("context level not code plus one");
  ctx_free_a: assert property (@(posedge clk_sys) disable iff (srst)
    (ctx.code == CTX_UNASSIGNED) |-> (!ctx.assigned && ctx.level == 3'h0))
    else $error("unassigned code gave a level");

endmodule

// File: dcfg_config_id_otp_tb_top.sv
module dcfg_config_id_otp_tb_top
  import dcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Arbitrary identity values
  localparam logic [7:0] FAM = 8'h3C;
  localparam logic [7:0] PART = 8'h07;
  localparam logic [3:0] REV = 4'h9;

  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [23:0] nvOptWord = 24'h00_0000;
  logic [23:0] nvCtxWord = 24'h00_0000;
  logic smbusModeEnable = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, hostSpiUseRemap, smbusHighLevelEnable;
  logic smbusInputHighLevel, i2cDefaultPins, configLoaded;
  logic [11:0] ctxLevel;
  logic [3:0] ctxAssigned;
  int mismatches = 0;
  int nTests = 0;

  always #10 clk_sys = ~clk_sys;

  dcfg_config_id_otp #(.FAMILY_CODE(FAM), .PART_CODE(PART), .REVISION(REV)) dut (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .nvOptWord(nvOptWord), .nvCtxWord(nvCtxWord), .smbusModeEnable(smbusModeEnable),
    .hostSpiUseRemap(hostSpiUseRemap), .smbusHighLevelEnable(smbusHighLevelEnable),
    .smbusInputHighLevel(smbusInputHighLevel), .i2cDefaultPins(i2cDefaultPins),
    .ctxLevel(ctxLevel), .ctxAssigned(ctxAssigned), .configLoaded(configLoaded)
  );

  // ==========================================================
  // Reporting
  task report_and_stop;
    $display("checks %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // Bus master
  task wait_ready;
    int k;
    k = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        mismatches++;
        report_and_stop();
      end
      @(posedge clk_sys);
    end
  endtask

  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0_0000, a};
    hsize <= HSIZE_WORD;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task rd(input logic [11:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000, x);
  endtask

  task rd_check(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    rd(a, x);
    check(x, exp);
  endtask

  // ==========================================================
  // Scenarios
  task test_config(input logic [23:0] opt, input logic [23:0] ctx);
    logic [11:0] lvl;
    logic [3:0] asg;
    logic [2:0] c;
    for (int n = 0; n < 4; n++) begin
      c = ctx[4*n +: 3];
      asg[n] = (c != 3'h7);
      lvl[3*n +: 3] = (c == 3'h7) ? 3'h0 : c + 3'h1;
    end
    srst <= 1'b1;
    nvOptWord <= opt;
    nvCtxWord <= ctx;
    repeat (3) @(posedge clk_sys);
    check(32'(configLoaded), 32'h0000_0000);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(32'(configLoaded), 32'h0000_0001);
    rd_check(ADDR_OPT, {8'h00, opt | OPT_UNIMPL_MASK});
    rd_check(ADDR_CTX, {8'h00, ctx | CTX_UNIMPL_MASK});
    check(32'(hostSpiUseRemap), 32'(opt[13]));
    check(32'(smbusHighLevelEnable), 32'(opt[10]));
    check(32'(i2cDefaultPins), 32'(opt[3]));
    check(32'(ctxLevel), 32'(lvl));
    check(32'(ctxAssigned), 32'(asg));
    smbusModeEnable <= 1'b0;
    @(posedge clk_sys);
    check(32'(smbusInputHighLevel), 32'h0000_0000);
    smbusModeEnable <= 1'b1;
    @(posedge clk_sys);
    check(32'(smbusInputHighLevel), 32'(opt[10]));
    wr(ADDR_OPT, 32'h0000_0000);
    wr(ADDR_CTX, 32'h0000_0000);
    rd_check(ADDR_OPT, {8'h00, opt | OPT_UNIMPL_MASK});
    rd_check(ADDR_CTX, {8'h00, ctx | CTX_UNIMPL_MASK});
    check(32'(ctxLevel), 32'(lvl));
    $display("test_config %h %h done", opt, ctx);
  endtask

  task test_ident;
    rd_check(ADDR_REV, {28'h000_0000, REV});
    rd_check(ADDR_ID, {16'h0000, FAM, PART});
    wr(ADDR_REV, 32'hFFFF_FFFF);
    wr(ADDR_ID, 32'hFFFF_FFFF);
    rd_check(ADDR_REV, {28'h000_0000, REV});
    rd_check(ADDR_ID, {16'h0000, FAM, PART});
    rd_check(12'h0F0, 32'h0000_0000);
    $display("test_ident done");
  endtask

  task test_otp;
    logic [31:0] x;
    wr(ADDR_STAGE, 32'h0000_ABCD);
    wr(ADDR_OTP_BASE, 32'h1234_5678);
    wr(ADDR_STAGE, 32'h0000_0F0F);
    wr(12'h2F8, 32'h5EED_0001);
    rd_check(ADDR_OTP_BASE, 32'h1234_5678);
    rd(12'h104, x);
    check(32'(x[15:0]), 32'h0000_ABCD);
    rd_check(12'h2F8, 32'h5EED_0001);
    rd(12'h2FC, x);
    check(32'(x[15:0]), 32'h0000_0F0F);
    rd_check(12'h108, 32'hFFFF_FFFF);
    wr(ADDR_STAGE, 32'h0000_1111);
    wr(ADDR_OTP_BASE, 32'h0000_0000);
    wr(12'h104, 32'h0000_0000);
    rd_check(ADDR_OTP_BASE, 32'h1234_5678);
    rd(12'h104, x);
    check(32'(x[15:0]), 32'h0000_ABCD);
    rd(ADDR_STATUS, x);
    check(32'(x[0]), 32'h0000_0001);
    wr(ADDR_STATUS, 32'h0000_0001);
    rd(ADDR_STATUS, x);
    check(32'(x[0]), 32'h0000_0000);
    wr(ADDR_ERASE, 32'h0000_0001);
    rd_check(ADDR_OTP_BASE, 32'h1234_5678);
    rd_check(12'h2F8, 32'h5EED_0001);
    rd(12'h104, x);
    check(32'(x[15:0]), 32'h0000_ABCD);
    rd(ADDR_STATUS, x);
    check(32'(x[1]), 32'h0000_0001);
    rd(ADDR_STAGE, x);
    check(32'(x[15:0]), 32'h0000_FFFF);
    $display("test_otp done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    test_config(24'h00_0000, 24'h00_3210);
    test_config(24'h00_2408, 24'h00_7654);
    test_ident();
    test_otp();
    report_and_stop();
  end
endmodule
